// File: dac_i2c_map.svh
`ifndef DAC_I2C_MAP_SVH
`define DAC_I2C_MAP_SVH

// ***********************************************************
// bus address
// ***********************************************************
`define DEV_ADDR_HI 5'h03
`define ADDR_LO_GND 2'h3
`define ADDR_LO_VDD 2'h0
`define ADDR_LO_OPEN 2'h2
`define MASTER_CODE_HI 5'h01

// ***********************************************************
// command word layout and reset values
// ***********************************************************
`define CMD_TOP_BIT 15
`define CMD_LOW_BYTE_MSB 7
`define CODE_MSB 11
`define CMD_WORD_RESET 16'h0000
`define READBACK_EMPTY 16'h0000
`define CODE_RESET 12'h000

// ***********************************************************
// byte framing
// ***********************************************************
`define BIT_LAST 3'h7

`endif

// File: dac_i2c_pkg.sv
`include "dac_i2c_map.svh"

package dac_i2c_pkg;

    // ***********************************************************
    // link state machine
    // ***********************************************************
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WR_BYTE = 7'h08,
        ST_WR_ACK = 7'h10,
        ST_RD_BYTE = 7'h20,
        ST_RD_ACK = 7'h40
    } link_state_t;

    // ***********************************************************
    // operating modes and address strap
    // ***********************************************************
    typedef enum logic [1:0] {
        PD_NORMAL = 2'h0,
        PD_1K_GND = 2'h1,
        PD_100K_GND = 2'h2,
        PD_THREE_STATE = 2'h3
    } pd_mode_t;

    typedef enum logic [1:0] {
        SENSE_GND = 2'h0,
        SENSE_VDD = 2'h1,
        SENSE_OPEN = 2'h2,
        SENSE_SPARE = 2'h3
    } addr_sense_t;

    // ***********************************************************
    // carriers
    // ***********************************************************
    typedef struct packed {
        logic command_word_top_bit;
        logic reserved_low;
        logic power_down_mode_high_bit;
        logic power_down_mode_low_bit;
        logic [`CODE_MSB:0] code;
    } cmd_word_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic [1:0] sense;
    } link_pins_t;

endpackage

// File: sync2.sv
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_in) begin
        meta <= d_in;
        q_out <= meta;
    end

endmodule // sync2

`default_nettype wire

// File: word_cdc.sv
`timescale 1ns/10ps
`default_nettype none

module word_cdc #(
    parameter int W = 16
) (
    input wire logic src_clk_in,
    input wire logic src_rst_in,
    input wire logic load_in,
    input wire logic [W-1:0] data_in,
    input wire logic dst_clk_in,
    input wire logic dst_rst_in,
    output logic strobe_out,
    output logic [W-1:0] data_out
);

    logic [W-1:0] hold;
    logic tgl;
    logic tgl_meta;
    logic tgl_s;
    logic tgl_d;
    wire tgl_edge = tgl_s ^ tgl_d;

    // source holds the word stable until the next load
    always_ff @(posedge src_clk_in) begin
        if (src_rst_in) begin
            hold <= '0;
            tgl <= 1'b0;
        end else if (load_in) begin
            hold <= data_in;
            tgl <= ~tgl;
        end
    end

    always_ff @(posedge dst_clk_in) begin
        if (dst_rst_in) begin
            tgl_meta <= 1'b0;
            tgl_s <= 1'b0;
            tgl_d <= 1'b0;
        end else begin
            tgl_meta <= tgl;
            tgl_s <= tgl_meta;
            tgl_d <= tgl_s;
        end
    end

    always_ff @(posedge dst_clk_in) begin
        if (dst_rst_in) begin
            strobe_out <= 1'b0;
            data_out <= '0;
        end else begin
            strobe_out <= tgl_edge;
            if (tgl_edge) begin
                data_out <= hold;
            end
        end
    end

endmodule // word_cdc

`default_nettype wire

// File: dac_i2c_slave.sv
// Function
// - address is 00011 plus two strap bits
// - strap gnd 11, supply 00, open 10
// - standard, fast and high-speed bus rates
// - no ten-bit or general call acknowledge
// - acknowledge own address, else idle
// - bytes are eight bits plus acknowledge
// - data line changes only while clock low
// - sixteen-bit command word, top bit first
// - two reserved, two mode, right-justified code
// - mode bits select normal or power-down
// - code cleared to zero at power-up
// - power-down keeps stored code unchanged
// - write: start, address with write, ack
// - high byte, low byte, each acknowledged
// - read: address with read, two bytes out
// - readback last word, then zero
// - master code enters high-speed, never acked
// - high-speed kept until stop condition
`timescale 1ns/10ps
`default_nettype none
`include "dac_i2c_map.svh"

module dac_i2c_slave
    import dac_i2c_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic link_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [1:0] addr_sense_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    output logic [`CODE_MSB:0] dac_code_out,
    output logic [1:0] power_down_mode_out,
    output logic code_valid_out,
    output logic hs_mode_out
);

    // ***********************************************************
    // link reset and pin sampling
    // ***********************************************************
    logic link_rst, scl_d, sda_d;
    link_pins_t pins_raw, pins_s;

    sync2 #(.W(1)) u_rst_sync (
        .clk_in(link_clk_in),
        .d_in(srst_in),
        .q_out(link_rst)
    );

    // pins oversampled on the link clock, fast enough for hs rate
    assign pins_raw = '{scl: scl_in, sda: sda_in, sense: addr_sense_in};

    sync2 #(.W(4)) u_pin_sync (
        .clk_in(link_clk_in),
        .d_in(pins_raw),
        .q_out(pins_s)
    );

    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= pins_s.scl;
            sda_d <= pins_s.sda;
        end
    end

    // ***********************************************************
    // bus events
    // ***********************************************************
    wire scl_rise = pins_s.scl & ~scl_d;
    wire scl_fall = ~pins_s.scl & scl_d;
    wire scl_held = pins_s.scl & scl_d;
    wire start_det = scl_held & sda_d & ~pins_s.sda;
    wire stop_det = scl_held & ~sda_d & pins_s.sda;

    // ***********************************************************
    // address decode
    // ***********************************************************
    logic [1:0] addr_lo;
    logic [6:0] own_addr;
    logic [7:0] shift;

    assign addr_lo = (pins_s.sense == SENSE_GND) ? `ADDR_LO_GND :
                     (pins_s.sense == SENSE_VDD) ? `ADDR_LO_VDD :
                     `ADDR_LO_OPEN;
    assign own_addr = {`DEV_ADDR_HI, addr_lo};
    // general call and ten-bit headers never equal own address
    wire addr_match = (shift[7:1] == own_addr);
    wire is_master_code = (shift[7:3] == `MASTER_CODE_HI);
    wire rw_read = shift[0];

    // ***********************************************************
    // link state
    // ***********************************************************
    link_state_t state, next_state;
    logic [2:0] bitcnt;
    logic got8, rd_mode, byte_idx, master_ack;
    logic hs_mode, rb_armed, next_oe_n, sda_oe_n;
    logic [7:0] hi_byte, rb_lo, tx, next_tx;
    logic [15:0] last_word;

    wire in_addr = (state == ST_ADDR);
    wire in_wr = (state == ST_WR_BYTE);
    wire in_rd = (state == ST_RD_BYTE);
    wire byte_state = in_addr | in_wr | in_rd;
    wire ev_addr_done = in_addr & got8 & scl_fall;
    wire ev_wr_done = in_wr & got8 & scl_fall;
    wire ev_addr_ack_end = (state == ST_ADDR_ACK) & scl_fall;
    wire ev_wr_ack_end = (state == ST_WR_ACK) & scl_fall;
    wire ev_rd_ack_end = (state == ST_RD_ACK) & scl_fall;
    wire rd_more = master_ack & ~byte_idx;
    wire commit = ev_wr_ack_end & byte_idx & ~start_det & ~stop_det;
    wire [15:0] rb_word = rb_armed ? last_word : `READBACK_EMPTY;
    wire [15:0] rx_word = {hi_byte, shift};

    always_comb begin
        next_state = state;
        if (stop_det) begin
            next_state = ST_IDLE;
        end else if (start_det) begin
            next_state = ST_ADDR;
        end else begin
            case (state)
                ST_IDLE: next_state = ST_IDLE;
                ST_ADDR: next_state = !ev_addr_done ? state :
                    addr_match ? ST_ADDR_ACK : ST_IDLE;
                ST_ADDR_ACK: next_state = !scl_fall ? state :
                    rd_mode ? ST_RD_BYTE : ST_WR_BYTE;
                ST_WR_BYTE: next_state = ev_wr_done ? ST_WR_ACK : state;
                ST_WR_ACK: next_state = scl_fall ? ST_WR_BYTE : state;
                ST_RD_BYTE: next_state = scl_fall && got8 ? ST_RD_ACK : state;
                ST_RD_ACK: next_state = !scl_fall ? state :
                    rd_more ? ST_RD_BYTE : ST_IDLE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    // data line only moves on a clock fall, or released at start/stop
    always_comb begin
        next_tx = tx;
        next_oe_n = sda_oe_n;
        if (start_det || stop_det) begin
            next_oe_n = 1'b1;
        end else if (ev_addr_done) begin
            next_oe_n = ~addr_match;
        end else if (ev_addr_ack_end) begin
            next_tx = rb_word[15:8];
            next_oe_n = rd_mode ? rb_word[15] : 1'b1;
        end else if (ev_wr_done) begin
            next_oe_n = 1'b0;
        end else if (ev_wr_ack_end) begin
            next_oe_n = 1'b1;
        end else if (in_rd && scl_fall) begin
            next_tx = {tx[6:0], 1'b1};
            next_oe_n = got8 ? 1'b1 : tx[6];
        end else if (ev_rd_ack_end) begin
            next_tx = rb_lo;
            next_oe_n = rd_more ? rb_lo[`CMD_LOW_BYTE_MSB] : 1'b1;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
            tx <= 8'hff;
        end else begin
            state <= next_state;
            sda_oe_n <= next_oe_n;
            tx <= next_tx;
        end
    end

    // bit counting: eight data pulses per byte
    always_ff @(posedge link_clk_in) begin
        if (link_rst || start_det || (scl_fall && got8)) begin
            bitcnt <= 3'h0;
            got8 <= 1'b0;
        end else if (byte_state && scl_rise) begin
            bitcnt <= bitcnt + 3'h1;
            got8 <= (bitcnt == `BIT_LAST);
        end
    end

    // receive shift, top bit first
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            shift <= 8'h00;
        end else if ((in_addr || in_wr) && scl_rise) begin
            shift <= {shift[6:0], pins_s.sda};
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            rd_mode <= 1'b0;
            byte_idx <= 1'b0;
        end else if (ev_addr_done) begin
            rd_mode <= rw_read;
            byte_idx <= 1'b0;
        end else if (ev_wr_ack_end || ev_rd_ack_end) begin
            byte_idx <= ~byte_idx;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            master_ack <= 1'b0;
        end else if ((state == ST_RD_ACK) && scl_rise) begin
            master_ack <= ~pins_s.sda;
        end
    end
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            hi_byte <= 8'h00;
        end else if (ev_wr_done && !byte_idx) begin
            hi_byte <= shift;
        end
    end
    // readback word latched once, armed by each committed write
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            last_word <= `CMD_WORD_RESET;
            rb_armed <= 1'b0;
            rb_lo <= 8'h00;
        end else if (commit) begin
            last_word <= rx_word;
            rb_armed <= 1'b1;
        end else if (ev_addr_ack_end && rd_mode) begin
            rb_lo <= rb_word[7:0];
            rb_armed <= 1'b0;
        end
    end
    always_ff @(posedge link_clk_in) begin
        if (link_rst || stop_det) begin
            hs_mode <= 1'b0;
        end else if (ev_addr_done && is_master_code) begin
            hs_mode <= 1'b1;
        end
    end
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            sda_out <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else begin
            sda_out <= 1'b0;
            sda_oe_n_out <= next_oe_n;
        end
    end

    // ***********************************************************
    // crossing to the system clock
    // ***********************************************************
    logic word_strobe;
    cmd_word_t word_q;
    pd_mode_t word_mode;

    word_cdc #(.W(16)) u_word_cdc (
        .src_clk_in(link_clk_in),
        .src_rst_in(link_rst),
        .load_in(commit),
        .data_in(rx_word),
        .dst_clk_in(clk_in),
        .dst_rst_in(srst_in),
        .strobe_out(word_strobe),
        .data_out(word_q)
    );

    sync2 #(.W(1)) u_hs_sync (
        .clk_in(clk_in),
        .d_in(hs_mode),
        .q_out(hs_mode_out)
    );

    // ***********************************************************
    // code and mode registers
    // ***********************************************************
    // reserved bits are ignored
    assign word_mode = pd_mode_t'({word_q.power_down_mode_high_bit,
                                   word_q.power_down_mode_low_bit});
    wire load_code = word_strobe && (word_mode == PD_NORMAL);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dac_code_out <= `CODE_RESET;
            power_down_mode_out <= PD_NORMAL;
            code_valid_out <= 1'b0;
        end else if (word_strobe) begin
            power_down_mode_out <= word_mode;
            code_valid_out <= 1'b1;
            if (load_code) begin
                dac_code_out <= word_q.code;
            end
        end
    end

    // ***********************************************************
    // checks
    // ***********************************************************
    a_addr_ack: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        (ev_addr_done && addr_match && !start_det && !stop_det)
        |=> (!sda_oe_n_out && state == ST_ADDR_ACK))
        else $error("own address not acknowledged");
    a_no_foreign_ack: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        (ev_addr_done && !addr_match) |=> (sda_oe_n_out && state == ST_IDLE))
        else $error("foreign address acknowledged");
    a_sda_low_clock: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        $changed(sda_oe_n_out)
        |-> (!scl_d || $past(start_det) || $past(stop_det)))
        else $error("data line moved while clock high");
    a_ack_ninth: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        (state == ST_WR_BYTE && next_state == ST_WR_ACK)
        |-> (bitcnt == 3'h0 && got8))
        else $error("acknowledge not after eight bits");
    a_hs_enter: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        (ev_addr_done && is_master_code && !stop_det)
        |=> (hs_mode && sda_oe_n_out) ##1 hs_mode)
        else $error("master code handling wrong");
    a_hs_hold: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        (hs_mode && start_det) |=> hs_mode)
        else $error("high-speed state lost at repeated start");
    a_hs_exit: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        stop_det |=> !hs_mode)
        else $error("high-speed state kept after stop");
    a_commit_point: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        commit |-> ($past(state == ST_WR_ACK) && byte_idx && $past(!sda_oe_n_out)))
        else $error("word committed outside low byte acknowledge");
    a_readback_first: assert property (
        @(posedge link_clk_in) disable iff (link_rst)
        (ev_addr_ack_end && rd_mode && !start_det && !stop_det)
        |=> (sda_oe_n_out == $past(rb_word[15]) && !rb_armed))
        else $error("readback first bit wrong");
    a_pd_keeps_code: assert property (
        @(posedge clk_in) disable iff (srst_in)
        (word_strobe && word_mode != PD_NORMAL)
        |=> ($stable(dac_code_out) && power_down_mode_out == $past(word_mode)))
        else $error("power-down disturbed stored code");
    a_code_load: assert property (
        @(posedge clk_in) disable iff (srst_in)
        load_code |=> (dac_code_out == $past(word_q.code) && code_valid_out))
        else $error("code not loaded from command word");

endmodule // dac_i2c_slave

`default_nettype wire

// File: i2c_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// ********
// bus master
// ********
module i2c_master_model #(
    parameter int Q = 20 // quarter bit in clk cycles, 3.125 MHz
) (
    input wire logic clk_in,
    input wire logic dev_oe_n_in,
    input wire logic dev_sda_in,
    output logic scl_out,
    output logic sda_line_out
);
    logic m_sda;
    initial begin
        scl_out = 1'b1;
        m_sda = 1'b1;
    end
    // open drain wire with pull-up
    assign sda_line_out = m_sda & (dev_oe_n_in | dev_sda_in);
    task automatic wq();
        repeat (Q) @(posedge clk_in);
    endtask
    // also serves as repeated start
    task automatic start();
        m_sda <= 1'b1;
        wq();
        scl_out <= 1'b1;
        wq();
        m_sda <= 1'b0;
        wq();
        scl_out <= 1'b0;
        wq();
    endtask
    task automatic stop();
        m_sda <= 1'b0;
        wq();
        scl_out <= 1'b1;
        wq();
        m_sda <= 1'b1;
        repeat (2) wq();
    endtask
    task automatic xbit(input logic b, output logic r);
        m_sda <= b;
        wq();
        scl_out <= 1'b1;
        wq();
        r = sda_line_out;
        wq();
        scl_out <= 1'b0;
        wq();
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ack_in,
        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
            q[i] = r;
        end
        xbit(ack_in, ack);
    endtask
endmodule // i2c_master_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none

// ********
// bench
// ********
module tb;
    logic clk, link_clk, srst, scl, sda_line, sda_drv, oe_n, valid, hs;
    logic oe_q;
    logic [1:0] sense, pd;
    logic [11:0] code;
    logic [6:0] own;
    logic [15:0] rdw;
    logic [1:0] lo_tab [4] = '{2'h3, 2'h0, 2'h2, 2'h2};
    int errors, n_tests;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    dac_i2c_slave dut (.clk_in(clk), .srst_in(srst), .link_clk_in(link_clk),
        .scl_in(scl), .sda_in(sda_line), .addr_sense_in(sense),
        .sda_out(sda_drv), .sda_oe_n_out(oe_n), .dac_code_out(code),
        .power_down_mode_out(pd), .code_valid_out(valid),
        .hs_mode_out(hs));
    i2c_master_model #(.Q(20)) master (.clk_in(clk), .dev_oe_n_in(oe_n),
        .dev_sda_in(sda_drv), .scl_out(scl), .sda_line_out(sda_line));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic nack);
        logic [7:0] q;
        logic ak;
        master.xbyte(b, 1'b1, q, ak);
        check({15'h0, ak}, {15'h0, nack});
    endtask
    task automatic wr(input logic [15:0] w);
        master.start();
        send({own, 1'b0}, 1'b0);
        send(w[15:8], 1'b0);
        send(w[7:0], 1'b0);
        master.stop();
    endtask
    task automatic rd(input logic [15:0] exp);
        logic ak;
        master.start();
        send({own, 1'b1}, 1'b0);
        master.xbyte(8'hff, 1'b0, rdw[15:8], ak);
        master.xbyte(8'hff, 1'b1, rdw[7:0], ak);
        master.stop();
        check(rdw, exp);
    endtask
    task automatic outs(input logic [11:0] c, input logic [1:0] p,
        input logic v);
        check({4'h0, code}, {4'h0, c});
        check({14'h0, pd}, {14'h0, p});
        check({15'h0, valid}, {15'h0, v});
    endtask

    // device drive must not move while clock high
    always @(posedge clk) begin
        oe_q <= oe_n;
        if (!srst && scl === 1'b1 && oe_q !== oe_n) begin
            errors++;
            $display("MISMATCH at %0t: data moved with clock high", $time);
        end
    end

    initial begin
        #300us;
        errors++;
        $display("MISMATCH at %0t: run timed out", $time);
        give_verdict();
    end

    initial begin
        srst = 1'b1;
        sense = 2'h0;
        own = {5'h03, 2'h3};
        errors = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (30) @(posedge clk);
        outs(12'h000, 2'h0, 1'b0);
        check({15'h0, hs}, 16'h0000);
        check({15'h0, oe_n}, 16'h0001);
        rd(16'h0000);
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            sense <= s[1:0];
            for (int a = 0; a < 4; a++) begin
                master.start();
                send({5'h03, a[1:0], 1'b0}, a[1:0] != lo_tab[s]);
                master.stop();
            end
        end
        sense <= 2'h0;
        for (int i = 0; i < 2; i++) begin
            master.start();
            send(i == 0 ? 8'h00 : 8'hf0, 1'b1);
            master.stop();
        end
        $display("test address done");
        master.start();
        send({own, 1'b0}, 1'b0);
        send(8'h0f, 1'b0);
        master.stop();
        outs(12'h000, 2'h0, 1'b0);
        wr(16'h0abc);
        outs(12'habc, 2'h0, 1'b1);
        rd(16'h0abc);
        rd(16'h0000);
        $display("test write read done");
        for (int md = 1; md < 4; md++) begin
            wr({2'b00, md[1:0], 12'h555});
            outs(12'habc, md[1:0], 1'b1);
        end
        wr(16'h0123);
        outs(12'h123, 2'h0, 1'b1);
        master.start();
        send({own, 1'b0}, 1'b0);
        send(8'h01, 1'b0);
        send(8'h11, 1'b0);
        send(8'h02, 1'b0);
        send(8'h22, 1'b0);
        master.stop();
        outs(12'h222, 2'h0, 1'b1);
        $display("test modes done");
        master.start();
        send(8'h09, 1'b1);
        check({15'h0, hs}, 16'h0001);
        master.start();
        send({own, 1'b0}, 1'b0);
        send(8'h04, 1'b0);
        send(8'h56, 1'b0);
        check({15'h0, hs}, 16'h0001);
        master.stop();
        check({15'h0, hs}, 16'h0000);
        outs(12'h456, 2'h0, 1'b1);
        $display("test high speed done");
        give_verdict();
    end
endmodule // tb
`default_nettype wire
